// ---- src/async_in_sync.sv ----
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ns
`default_nettype none
module async_in_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  // pins
  input  wire logic [W-1:0] i_pin,
  // filtered levels
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_level_q
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;

      // first stage feeds only the second
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          s1_q <= bus_arb_pkg::IN_RST_LEVEL;
          s2_q <= bus_arb_pkg::IN_RST_LEVEL;
          s3_q <= bus_arb_pkg::IN_RST_LEVEL;
        end else begin
          s1_q <= i_pin[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      // a change counts once stages two and three agree
      assign o_level[g] = (s2_q == s3_q) ? s3_q : lvl_q;

      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          lvl_q <= bus_arb_pkg::IN_RST_LEVEL;
        end else begin
          lvl_q <= o_level[g];
        end
      end

      assign o_level_q[g] = lvl_q;
    end
  endgenerate

endmodule
`default_nettype wire

// ---- src/bus_arb_pkg.sv ----
// constants shared by the bus grant arbitration logic
package bus_arb_pkg;

  // times are held in tenths of a processor clock, as printed in clocks
  localparam int unsigned TENTHS_PER_CLK        = 10;
  localparam int unsigned GAP_MIN_TENTHS        = 15;
  localparam int unsigned STROBE_DRIVE_MIN_TENTHS = 15;
  localparam int unsigned FC_DRIVE_MIN_TENTHS   = 10;

  // least times round up to whole cycles
  localparam int unsigned GAP_MIN_CYC =
    (GAP_MIN_TENTHS + TENTHS_PER_CLK - 1) / TENTHS_PER_CLK;
  localparam int unsigned STROBE_DRIVE_MIN_CYC =
    (STROBE_DRIVE_MIN_TENTHS + TENTHS_PER_CLK - 1) / TENTHS_PER_CLK;
  localparam int unsigned FC_DRIVE_MIN_CYC =
    (FC_DRIVE_MIN_TENTHS + TENTHS_PER_CLK - 1) / TENTHS_PER_CLK;

  // counters and synchroniser
  localparam int unsigned CNT_W       = 3;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned ASYNC_W     = 8;
  localparam int unsigned IPL_W       = 3;

  // values after reset
  localparam logic        IN_RST_LEVEL = 1'h1;
  localparam logic [2:0]  CNT_RST      = 3'h0;

  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_WAIT,
    ARB_GRANTED,
    ARB_RESUME
  } arb_state_t;

endpackage

// ---- src/bus_grant_arbiter.sv ----
// bus request / grant arbitration for the processor's external bus
// Function
// - a seen bus request raises the grant within 1.5 to 3.5 clocks (the grant here also waits for i_cycle_busy to fall).
// - a withdrawn request drops the grant within 1.5 to 3.5 clocks.
// - strobes and read/write are driven again no sooner than 1.5 clocks after withdrawal.
// - function code lines are driven again no sooner than 1 clock after withdrawal.
// - if the request returns during the wait to drive again, the grant may be given again.
// - bus error, request, acknowledge, interrupt level and peripheral inputs are synchronised.
// - once granted with the address strobe negated, control, address and data float.
// - the grant stays negated at least 1.5 clocks between two grants.
`timescale 1ns/1ns
`default_nettype none
module bus_grant_arbiter (
  // clock and reset
  input  wire logic                            i_clk,
  input  wire logic                            i_nrst,
  // asynchronous pins
  input  wire logic                            i_bus_request_n,
  input  wire logic                            i_bus_error_in_n,
  input  wire logic                            i_transfer_ack_n,
  input  wire logic [bus_arb_pkg::IPL_W-1:0]   i_interrupt_level_n,
  input  wire logic                            i_valid_peripheral_address_n,
  input  wire logic                            i_autovector_req_n,
  // processor core
  input  wire logic                            i_cycle_busy,
  output logic                                 o_core_hold,
  // arbitration pins
  output logic                                 o_bus_grant_n,
  output logic                                 o_strobe_oe_n,
  output logic                                 o_addr_data_oe_n,
  output logic                                 o_fc_oe_n,
  // synchronised inputs to the core
  output logic                                 o_bus_error_n,
  output logic                                 o_transfer_ack_n,
  output logic [bus_arb_pkg::IPL_W-1:0]        o_interrupt_level_n,
  output logic                                 o_valid_peripheral_address_n,
  output logic                                 o_autovector_req_n,
  output logic                                 o_bus_request_n
);

  logic [bus_arb_pkg::ASYNC_W-1:0] pins;
  logic [bus_arb_pkg::ASYNC_W-1:0] lvl;
  logic [bus_arb_pkg::ASYNC_W-1:0] lvl_q;
  logic                            req;

  assign pins = {
    i_bus_request_n,
    i_bus_error_in_n,
    i_transfer_ack_n,
    i_interrupt_level_n,
    i_valid_peripheral_address_n,
    i_autovector_req_n
  };

  // all asynchronous inputs pass the same filter
  async_in_sync #(
    .W         (bus_arb_pkg::ASYNC_W)
  ) u_sync (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_pin     (pins),
    .o_level   (lvl),
    .o_level_q (lvl_q)
  );

  assign req = ~lvl[7];

  assign o_bus_request_n              = lvl_q[7];
  assign o_bus_error_n                = lvl_q[6];
  assign o_transfer_ack_n             = lvl_q[5];
  assign o_interrupt_level_n          = lvl_q[4:2];
  assign o_valid_peripheral_address_n = lvl_q[1];
  assign o_autovector_req_n           = lvl_q[0];

  bus_arb_pkg::arb_state_t          state_q;
  logic [bus_arb_pkg::CNT_W-1:0]    gap_q;
  logic [bus_arb_pkg::CNT_W-1:0]    cnt_q;
  logic                             grant_n_q;
  logic                             strobe_oe_n_q;
  logic                             addr_oe_n_q;
  logic                             fc_oe_n_q;
  logic                             hold_q;
  logic                             gap_ok;
  logic                             start_grant;
  logic                             regrant;
  logic                             drop_grant;
  logic                             fc_due;
  logic                             strobe_due;

  // the edge that lowers the grant again is itself one more negated cycle
  assign gap_ok = (gap_q >= bus_arb_pkg::CNT_W'(bus_arb_pkg::GAP_MIN_CYC - 1));

  // negated-grant width counter, saturating
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      gap_q <= bus_arb_pkg::CNT_RST;
    end else if (!grant_n_q) begin
      gap_q <= bus_arb_pkg::CNT_RST;
    end else if (!gap_ok) begin
      gap_q <= gap_q + 1'b1;
    end
  end

  // the core is held off starting new cycles while a request is pending
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= req | (state_q != bus_arb_pkg::ARB_IDLE);
    end
  end

  // grant straight from the filtered request, so pin to grant stays within 3.5 clocks unless i_cycle_busy holds it off;
  // the core sees the hold on that same edge and must not start a cycle on it
  assign start_grant = req && !i_cycle_busy && gap_ok &&
                       (state_q == bus_arb_pkg::ARB_IDLE ||
                        state_q == bus_arb_pkg::ARB_WAIT);
  assign regrant     = req && gap_ok && (state_q == bus_arb_pkg::ARB_RESUME);
  assign drop_grant  = !req && (state_q == bus_arb_pkg::ARB_GRANTED);
  assign fc_due      = (state_q == bus_arb_pkg::ARB_RESUME) && !regrant &&
                       (cnt_q >= bus_arb_pkg::CNT_W'(bus_arb_pkg::FC_DRIVE_MIN_CYC));
  assign strobe_due  = (state_q == bus_arb_pkg::ARB_RESUME) && !regrant &&
                       (cnt_q >= bus_arb_pkg::CNT_W'(bus_arb_pkg::STROBE_DRIVE_MIN_CYC));

  // arbitration sequence
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= bus_arb_pkg::ARB_IDLE;
    end else begin
      case (state_q)
        bus_arb_pkg::ARB_IDLE: begin
          if (start_grant) begin
            state_q <= bus_arb_pkg::ARB_GRANTED;
          end else if (req) begin
            state_q <= bus_arb_pkg::ARB_WAIT;
          end
        end
        bus_arb_pkg::ARB_WAIT: begin
          // a request dropped before the grant is forgotten
          if (!req) begin
            state_q <= bus_arb_pkg::ARB_IDLE;
          end else if (start_grant) begin
            state_q <= bus_arb_pkg::ARB_GRANTED;
          end
        end
        bus_arb_pkg::ARB_GRANTED: begin
          if (drop_grant) begin
            state_q <= bus_arb_pkg::ARB_RESUME;
          end
        end
        bus_arb_pkg::ARB_RESUME: begin
          // a returning request hands the bus straight back
          if (regrant) begin
            state_q <= bus_arb_pkg::ARB_GRANTED;
          end else if (strobe_due) begin
            state_q <= bus_arb_pkg::ARB_IDLE;
          end
        end
        default: begin
          state_q <= bus_arb_pkg::ARB_IDLE;
        end
      endcase
    end
  end

  // cycles since the withdrawal was seen, counted while waiting to drive again
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cnt_q <= bus_arb_pkg::CNT_RST;
    end else if (drop_grant) begin
      cnt_q <= bus_arb_pkg::CNT_W'(1);
    end else if ((state_q == bus_arb_pkg::ARB_RESUME) && !regrant && !strobe_due) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // grant pin
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      grant_n_q <= 1'h1;
    end else if (start_grant || regrant) begin
      grant_n_q <= 1'h0;
    end else if (drop_grant) begin
      grant_n_q <= 1'h1;
    end
  end

  // own cycle is done at a grant, so the address strobe is already negated
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      strobe_oe_n_q <= 1'h0;
      addr_oe_n_q   <= 1'h0;
    end else if (start_grant) begin
      strobe_oe_n_q <= 1'h1;
      addr_oe_n_q   <= 1'h1;
    end else if (strobe_due) begin
      strobe_oe_n_q <= 1'h0;
      addr_oe_n_q   <= 1'h0;
    end
  end

  // a re-grant floats the function code again if it was already driven
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      fc_oe_n_q <= 1'h0;
    end else if (start_grant || regrant) begin
      fc_oe_n_q <= 1'h1;
    end else if (fc_due) begin
      fc_oe_n_q <= 1'h0;
    end
  end

  assign o_bus_grant_n    = grant_n_q;
  assign o_strobe_oe_n    = strobe_oe_n_q;
  assign o_addr_data_oe_n = addr_oe_n_q;
  assign o_fc_oe_n        = fc_oe_n_q;
  assign o_core_hold      = hold_q;

endmodule
`default_nettype wire

// ---- verif/bus_grant_arbiter_test.sv ----
// self-checking bench for the bus grant arbiter
`timescale 1ns/1ns
`default_nettype none
module bus_grant_arbiter_test;
  logic       i_clk = 1'h0, i_nrst = 1'h0, go = 1'h0, busy = 1'h0;
  logic [3:0] tenure = 4'h0;
  logic [6:0] pins = 7'h7F;
  wire logic  [6:0] seen;
  wire logic  req_n, grant_n, st_oe_n, ad_oe_n, fc_oe_n, hold, seen_req_n;
  int         n_fail = 0, samples_checked = 0, cycles = 0, seed = 32'h2386, n, b, r;
  int         exp_q[$];

  always #25 i_clk = ~i_clk;

  ext_master_model bm (.i_clk(i_clk), .i_go(go), .i_tenure(tenure),
    .i_bus_grant_n(grant_n), .o_bus_request_n(req_n));
  bus_grant_arbiter dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus_request_n(req_n),
    .i_bus_error_in_n(pins[0]), .i_transfer_ack_n(pins[1]), .i_interrupt_level_n(pins[4:2]),
    .i_valid_peripheral_address_n(pins[5]), .i_autovector_req_n(pins[6]),
    .i_cycle_busy(busy), .o_core_hold(hold), .o_bus_grant_n(grant_n), .o_strobe_oe_n(st_oe_n),
    .o_addr_data_oe_n(ad_oe_n), .o_fc_oe_n(fc_oe_n), .o_bus_error_n(seen[0]),
    .o_transfer_ack_n(seen[1]), .o_interrupt_level_n(seen[4:2]),
    .o_valid_peripheral_address_n(seen[5]), .o_autovector_req_n(seen[6]),
    .o_bus_request_n(seen_req_n));

  task automatic tally_and_finish();
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'h1) begin
      n_fail++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  // w: 0 waits for grant, 1 for the request to drop, 2 for grant to drop
  task automatic steps(input int w);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
      if (n == b) busy <= 1'h0;
    end while ((w == 0 ? grant_n : w == 1 ? !req_n : !grant_n) !== 1'h0 && n < 40);
  endtask

  // a hang ends the run here rather than stalling forever
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(negedge i_clk);
    i_nrst <= 1'h1;
    @(negedge i_clk);
    check(grant_n === 1'h1 && st_oe_n === 1'h0 && ad_oe_n === 1'h0 && fc_oe_n === 1'h0 &&
          hold === 1'h0, "reset state");
    check(seen === 7'h7F && seen_req_n === 1'h1, "reset copies");
    for (int k = 0; k < 30; k++) begin
      b = (k % 3 == 2) ? 2 + k % 5 : 0;
      r = $random(seed);
      exp_q.push_back(r & 32'h7F);
      pins <= 7'(r);
      tenure <= 4'($random(seed));
      busy <= b > 0;
      go <= 1'h1;
      @(negedge i_clk);
      go <= 1'h0;
      steps(0);
      check(n >= 2 && n > b && n <= b + 4, "grant latency");
      check(st_oe_n === 1'h1 && ad_oe_n === 1'h1 && fc_oe_n === 1'h1 && hold === 1'h1,
            "bus not floated");
      check(seen_req_n === 1'h0, "request copy");
      b = 0;
      steps(1);
      steps(2);
      check(n >= 1 && n <= 3, "release latency");
      repeat (6) @(negedge i_clk);
      check(st_oe_n === 1'h0 && ad_oe_n === 1'h0 && fc_oe_n === 1'h0, "bus idle");
      check(seen === 7'(exp_q.pop_front()) && seen_req_n === 1'h1, "async input copy");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- verif/ext_master_model.sv ----
// model of the outside master that borrows the external bus
`timescale 1ns/1ns
`default_nettype none
module ext_master_model (
  // clock and bench control
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic [3:0] i_tenure,
  // arbitration pins
  input  wire logic       i_bus_grant_n,
  output var  logic       o_bus_request_n
);
  int held = 0;
  initial o_bus_request_n = 1'h1;
  // levels move on the falling edge, away from the sampling edge
  always @(negedge i_clk) begin
    if (o_bus_request_n && i_go) begin
      o_bus_request_n <= 1'h0;
      held <= 0;
    end else if (!o_bus_request_n && !i_bus_grant_n) begin
      held <= held + 1;
      // never dropped before the grant, so the device cannot forget it
      if (held == int'(i_tenure)) o_bus_request_n <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/grant_chk.sv ----
// assertions on the bus grant arbiter ports
`timescale 1ns/1ns
`default_nettype none
module grant_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // watched pins
  input wire logic i_bus_request_n,
  input wire logic i_transfer_ack_n,
  input wire logic i_cycle_busy,
  input wire logic o_bus_grant_n,
  input wire logic o_strobe_oe_n,
  input wire logic o_addr_data_oe_n,
  input wire logic o_fc_oe_n,
  input wire logic o_transfer_ack_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_grant_not_early: assert property ($fell(o_bus_grant_n) |-> !$past(i_bus_request_n))
    else $error("grant too early");
  a_grant_in_time: assert property ($fell(i_bus_request_n) ##0
    (!i_bus_request_n && !i_cycle_busy && o_bus_grant_n) [*4] |=> !o_bus_grant_n)
    else $error("grant too late");
  a_release_not_early: assert property ($rose(o_bus_grant_n) |-> $past(i_bus_request_n))
    else $error("grant dropped too early");
  a_release_in_time: assert property ($rose(i_bus_request_n) && !o_bus_grant_n
    ##1 i_bus_request_n [*3] |=> o_bus_grant_n)
    else $error("grant dropped too late");
  a_strobe_drive_wait: assert property ($fell(o_strobe_oe_n) |-> $past(i_bus_request_n))
    else $error("strobes driven too soon");
  a_fc_drive_wait: assert property ($fell(o_fc_oe_n) |-> $past(i_bus_request_n))
    else $error("function code driven too soon");
  a_granted_bus_floats: assert property (!o_bus_grant_n |-> o_strobe_oe_n && o_addr_data_oe_n)
    else $error("bus driven while granted");
  a_grant_gap_min: assert property ($rose(o_bus_grant_n) |=> o_bus_grant_n)
    else $error("grant gap too short");
  a_no_grant_busy: assert property ($fell(o_bus_grant_n) |-> !$past(i_cycle_busy))
    else $error("grant during own cycle");
  a_sync_ack_value: assert property ($changed(o_transfer_ack_n)
    |-> o_transfer_ack_n == $past(i_transfer_ack_n, 3))
    else $error("acknowledge copy wrong");
  c_grant: cover property ($fell(o_bus_grant_n));
  c_busy_wait: cover property (i_cycle_busy && !i_bus_request_n ##1 !i_cycle_busy);
  c_regrant: cover property ($rose(o_bus_grant_n) ##[2:20] $fell(o_bus_grant_n));
endmodule
bind bus_grant_arbiter grant_chk u_chk (
  .i_clk            (i_clk),
  .i_nrst           (i_nrst),
  .i_bus_request_n  (i_bus_request_n),
  .i_transfer_ack_n (i_transfer_ack_n),
  .i_cycle_busy     (i_cycle_busy),
  .o_bus_grant_n    (o_bus_grant_n),
  .o_strobe_oe_n    (o_strobe_oe_n),
  .o_addr_data_oe_n (o_addr_data_oe_n),
  .o_fc_oe_n        (o_fc_oe_n),
  .o_transfer_ack_n (o_transfer_ack_n)
);
`default_nettype wire
